// ==== logic/uscm_defs.vh ====
// register map, field positions, reset values and mode codes
`ifndef USCM_DEFS_VH
`define USCM_DEFS_VH
// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define USCM_OFF_CMD 8'h00
`define USCM_OFF_MODE 8'h04
`define USCM_OFF_IEN_SET 8'h08
`define USCM_OFF_IEN_CLR 8'h0c
`define USCM_OFF_IEN_VIEW 8'h10
`define USCM_OFF_STATUS 8'h14
`define USCM_OFF_RX_HOLD 8'h18
`define USCM_OFF_TX_HOLD 8'h1c
`define USCM_OFF_BAUD 8'h20
`define USCM_OFF_RTO 8'h24
`define USCM_OFF_GUARD 8'h28
`define USCM_OFF_FIDI 8'h40
`define USCM_OFF_NERR 8'h44
`define USCM_OFF_IRF 8'h4c
`define USCM_OFF_MAN 8'h50
`define USCM_OFF_CTLVIEW 8'h54
// -------------------------------------------------------------
// command bits
// -------------------------------------------------------------
`define USCM_CMD_RX_RST 2
`define USCM_CMD_TX_RST 3
`define USCM_CMD_RX_ON 4
`define USCM_CMD_RX_OFF 5
`define USCM_CMD_TX_ON 6
`define USCM_CMD_TX_OFF 7
`define USCM_CMD_STA_CLR 8
`define USCM_CMD_BRK_BEGIN 9
`define USCM_CMD_BRK_END 10
`define USCM_CMD_TO_ARM 11
`define USCM_CMD_ADDR_SEND 12
`define USCM_CMD_ITER_CLR 13
`define USCM_CMD_DTR_ON 16
`define USCM_CMD_DTR_OFF 17
`define USCM_CMD_RTS_ON 18
`define USCM_CMD_RTS_OFF 19
// -------------------------------------------------------------
// mode register fields (lsb positions)
// -------------------------------------------------------------
`define USCM_MR_OPMODE 0
`define USCM_MR_CLKSRC 4
`define USCM_MR_CHAR_LENGTH_FIELD 6
`define USCM_MR_SYNC 8
`define USCM_MR_PAR 9
`define USCM_MR_STOP 12
`define USCM_MR_CHANNEL_MODE_FIELD 14
`define USCM_MR_MSB_FIRST_SELECT 16
`define USCM_MR_NINE 17
// -------------------------------------------------------------
// status bits
// -------------------------------------------------------------
`define USCM_ST_BREAK_SEEN_FLAG 2
`define USCM_ST_OVR 5
`define USCM_ST_FRAME 6
`define USCM_ST_PAR 7
`define USCM_ST_TIMEOUT 8
`define USCM_ST_ITER 10
`define USCM_ST_MANCH 24
// -------------------------------------------------------------
// reset values, codes and counts
// -------------------------------------------------------------
`define USCM_RST_ZERO 32'h0000_0000
`define USCM_RST_FIDI 32'h0000_0174
`define USCM_RST_MAN 32'h3001_1004
`define USCM_OPM_NORMAL 4'h0
`define USCM_OPM_RS485 4'h1
`define USCM_OPM_HWHS 4'h2
`define USCM_OPM_MODEM 4'h3
`define USCM_OPM_ISO_T0 4'h4
`define USCM_OPM_ISO_T1 4'h6
`define USCM_OPM_IRDA 4'h8
`define USCM_CLK_RSVD 2'h2
`define USCM_STOP_HALF 2'h1
`define USCM_STOP_RSVD 2'h3
`define USCM_PAR_MDROP 2'h3
`define USCM_CHR_BASE 4'h5
`define USCM_CHR_NINE 4'h9
`define USCM_FRAME_EXTRA 4'h2
`define USCM_GUARD_BITS 4'hc
`define USCM_RESP_OK 2'h0
`define USCM_RESP_ERR 2'h2
`endif

// ==== logic/uscm_core.v ====
// serial transceiver command and mode front end with axi4-lite slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "uscm_defs.vh"
module uscm_core #(
  parameter ADDR_W = 8
) (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire [ADDR_W-1:0] s_axi_awaddr_i,
  input wire [2:0] s_axi_awprot_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [ADDR_W-1:0] s_axi_araddr_i,
  input wire [2:0] s_axi_arprot_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire tx_idle_i,
  input wire bit_tick_i,
  input wire rx_char_i,
  input wire parity_error_flag_i,
  input wire frame_error_i,
  input wire overrun_flag_i,
  input wire manchester_error_flag_i,
  input wire break_seen_flag_i,
  input wire timeout_i,
  input wire iteration_i,
  input wire [8:0] rx_data_i,
  input wire [7:0] error_count_i,
  output reg rx_enable_o,
  output reg tx_enable_o,
  output reg rx_reset_o,
  output reg tx_reset_o,
  output reg timeout_wait_o,
  output reg [8:0] tx_data_o,
  output reg tx_data_valid_o,
  output reg tx_addr_bit_o,
  output reg break_low_o,
  output reg break_guard_o,
  output reg dtr_n_o,
  output reg rts_n_o,
  output wire [3:0] op_mode_o,
  output wire [1:0] clock_source_field_o,
  output wire [3:0] char_bits_o,
  output wire sync_mode_o,
  output wire [2:0] parity_field_o,
  output wire [1:0] stop_bits_field_o,
  output wire [1:0] channel_mode_field_o,
  output wire msb_first_select_o,
  output wire cfg_valid_o,
  output wire [31:0] baud_divider_o,
  output wire [31:0] rx_timeout_value_o,
  output wire [31:0] tx_guard_time_o,
  output wire [31:0] smartcard_rate_ratio_o,
  output wire [31:0] infrared_filter_o,
  output wire [31:0] manchester_config_o,
  output wire [31:0] irq_enable_o
);

// ---------------------------------------------------------------
// break sequencer states
// ---------------------------------------------------------------
localparam [3:0] BRK_IDLE = 4'b0001;
localparam [3:0] BRK_WAIT = 4'b0010;
localparam [3:0] BRK_LOW = 4'b0100;
localparam [3:0] BRK_GUARD = 4'b1000;

reg aw_full_q;
reg w_full_q;
reg [ADDR_W-1:0] aw_addr_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;
reg [31:0] mode_q;
reg [31:0] baud_q;
reg [31:0] rto_q;
reg [31:0] guard_q;
reg [31:0] fidi_q;
reg [31:0] irf_q;
reg [31:0] man_q;
reg [31:0] ien_q;
reg [31:0] status_q;
reg [31:0] status_d;
reg [3:0] brk_state_q;
reg [3:0] brk_state_d;
reg [3:0] brk_cnt_q;
reg [3:0] brk_cnt_d;
reg brk_stop_q;
reg brk_stop_d;
reg addr_pend_q;
reg dtr_q;
reg rts_q;
reg [31:0] rd_data;
reg [1:0] rd_resp;
wire wr_go;
wire [31:0] wmask;
wire [31:0] cmd;
wire smartcard_mode;
wire multidrop;
wire [3:0] brk_min;

// ---------------------------------------------------------------
// axi4-lite write path
// ---------------------------------------------------------------
assign s_axi_awready_o = ~aw_full_q;
assign s_axi_wready_o = ~w_full_q;
assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid_o;
assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

function [31:0] merge;
  input [31:0] old_v;
  input [31:0] new_v;
  input [31:0] msk;
  begin
    merge = (old_v & ~msk) | (new_v & msk);
  end
endfunction

function wr_ok;
  input [ADDR_W-1:0] a;
  begin
    case (a)
      `USCM_OFF_CMD, `USCM_OFF_MODE, `USCM_OFF_IEN_SET, `USCM_OFF_IEN_CLR,
      `USCM_OFF_TX_HOLD, `USCM_OFF_BAUD, `USCM_OFF_RTO, `USCM_OFF_GUARD,
      `USCM_OFF_FIDI, `USCM_OFF_IRF, `USCM_OFF_MAN, `USCM_OFF_IEN_VIEW,
      `USCM_OFF_STATUS, `USCM_OFF_RX_HOLD, `USCM_OFF_NERR, `USCM_OFF_CTLVIEW:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
  end
endfunction

assign cmd = (wr_go && aw_addr_q == `USCM_OFF_CMD) ? (w_data_q & wmask) : 32'h0;

always @(posedge clk_sys_i)
begin
  if (!rstn_i)
  begin
    aw_full_q <= 1'b0;
    w_full_q <= 1'b0;
    aw_addr_q <= {ADDR_W{1'b0}};
    w_data_q <= 32'h0;
    w_strb_q <= 4'h0;
    s_axi_bvalid_o <= 1'b0;
    s_axi_bresp_o <= `USCM_RESP_OK;
  end
  else
  begin
    if (s_axi_awvalid_i && !aw_full_q)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr_i[ADDR_W-1:2], 2'b00};
    end
    if (s_axi_wvalid_i && !w_full_q)
    begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata_i;
      w_strb_q <= s_axi_wstrb_i;
    end
    if (wr_go)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_ok(aw_addr_q) ? `USCM_RESP_OK : `USCM_RESP_ERR;
    end
    else if (s_axi_bvalid_o && s_axi_bready_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
    end
  end
end

// ---------------------------------------------------------------
// configuration registers
// ---------------------------------------------------------------
always @(posedge clk_sys_i)
begin
  if (!rstn_i)
  begin
    mode_q <= `USCM_RST_ZERO;
    baud_q <= `USCM_RST_ZERO;
    rto_q <= `USCM_RST_ZERO;
    guard_q <= `USCM_RST_ZERO;
    fidi_q <= `USCM_RST_FIDI;
    irf_q <= `USCM_RST_ZERO;
    man_q <= `USCM_RST_MAN;
    ien_q <= `USCM_RST_ZERO;
  end
  else if (wr_go)
  begin
    case (aw_addr_q)
      `USCM_OFF_MODE: mode_q <= merge(mode_q, w_data_q, wmask);
      `USCM_OFF_BAUD: baud_q <= merge(baud_q, w_data_q, wmask);
      `USCM_OFF_RTO: rto_q <= merge(rto_q, w_data_q, wmask);
      `USCM_OFF_GUARD: guard_q <= merge(guard_q, w_data_q, wmask);
      `USCM_OFF_FIDI: fidi_q <= merge(fidi_q, w_data_q, wmask);
      `USCM_OFF_IRF: irf_q <= merge(irf_q, w_data_q, wmask);
      `USCM_OFF_MAN: man_q <= merge(man_q, w_data_q, wmask);
      `USCM_OFF_IEN_SET: ien_q <= ien_q | (w_data_q & wmask);
      `USCM_OFF_IEN_CLR: ien_q <= ien_q & ~(w_data_q & wmask);
      default: ien_q <= ien_q;
    endcase
  end
end

assign baud_divider_o = baud_q;
assign rx_timeout_value_o = rto_q;
assign tx_guard_time_o = guard_q;
assign smartcard_rate_ratio_o = fidi_q;
assign infrared_filter_o = irf_q;
assign manchester_config_o = man_q;
assign irq_enable_o = ien_q;

// ---------------------------------------------------------------
// mode field decode
// ---------------------------------------------------------------
assign op_mode_o = mode_q[`USCM_MR_OPMODE+3:`USCM_MR_OPMODE];
assign clock_source_field_o = mode_q[`USCM_MR_CLKSRC+1:`USCM_MR_CLKSRC];
assign char_bits_o = mode_q[`USCM_MR_NINE] ? `USCM_CHR_NINE :
  `USCM_CHR_BASE + {2'b00, mode_q[`USCM_MR_CHAR_LENGTH_FIELD+1:`USCM_MR_CHAR_LENGTH_FIELD]};
assign sync_mode_o = mode_q[`USCM_MR_SYNC];
assign parity_field_o = mode_q[`USCM_MR_PAR+2:`USCM_MR_PAR];
assign stop_bits_field_o = mode_q[`USCM_MR_STOP+1:`USCM_MR_STOP];
assign channel_mode_field_o = mode_q[`USCM_MR_CHANNEL_MODE_FIELD+1:`USCM_MR_CHANNEL_MODE_FIELD];
assign msb_first_select_o = mode_q[`USCM_MR_MSB_FIRST_SELECT];
assign smartcard_mode = (op_mode_o == `USCM_OPM_ISO_T0) || (op_mode_o == `USCM_OPM_ISO_T1);
assign multidrop = parity_field_o[2:1] == `USCM_PAR_MDROP;

// reserved codes flag an unusable setting
assign cfg_valid_o =
  ((op_mode_o == `USCM_OPM_NORMAL) || (op_mode_o == `USCM_OPM_RS485) ||
   (op_mode_o == `USCM_OPM_HWHS) || (op_mode_o == `USCM_OPM_MODEM) ||
   smartcard_mode || (op_mode_o == `USCM_OPM_IRDA)) &&
  (clock_source_field_o != `USCM_CLK_RSVD) &&
  (stop_bits_field_o != `USCM_STOP_RSVD) &&
  !(sync_mode_o && stop_bits_field_o == `USCM_STOP_HALF);

// ---------------------------------------------------------------
// command execution
// ---------------------------------------------------------------
always @(posedge clk_sys_i)
begin
  if (!rstn_i)
  begin
    rx_enable_o <= 1'b0;
    tx_enable_o <= 1'b0;
    rx_reset_o <= 1'b0;
    tx_reset_o <= 1'b0;
    timeout_wait_o <= 1'b0;
    addr_pend_q <= 1'b0;
    tx_data_o <= 9'h0;
    tx_data_valid_o <= 1'b0;
    tx_addr_bit_o <= 1'b0;
    dtr_q <= 1'b1;
    rts_q <= 1'b1;
    dtr_n_o <= 1'b1;
    rts_n_o <= 1'b1;
  end
  else
  begin
    rx_reset_o <= cmd[`USCM_CMD_RX_RST];
    tx_reset_o <= cmd[`USCM_CMD_TX_RST];
    if (cmd[`USCM_CMD_RX_OFF])
      rx_enable_o <= 1'b0;
    else if (cmd[`USCM_CMD_RX_ON])
      rx_enable_o <= 1'b1;
    if (cmd[`USCM_CMD_TX_OFF])
      tx_enable_o <= 1'b0;
    else if (cmd[`USCM_CMD_TX_ON])
      tx_enable_o <= 1'b1;
    if (cmd[`USCM_CMD_TO_ARM])
      timeout_wait_o <= 1'b1;
    else if (rx_char_i)
      timeout_wait_o <= 1'b0;
    tx_data_valid_o <= 1'b0;
    if (wr_go && aw_addr_q == `USCM_OFF_TX_HOLD)
    begin
      tx_data_o <= w_data_q[8:0];
      tx_data_valid_o <= 1'b1;
      tx_addr_bit_o <= addr_pend_q & multidrop;
      addr_pend_q <= 1'b0;
    end
    else if (cmd[`USCM_CMD_ADDR_SEND] && multidrop)
      addr_pend_q <= 1'b1;
    if (cmd[`USCM_CMD_DTR_OFF])
      dtr_q <= 1'b1;
    else if (cmd[`USCM_CMD_DTR_ON])
      dtr_q <= 1'b0;
    if (cmd[`USCM_CMD_RTS_OFF])
      rts_q <= 1'b1;
    else if (cmd[`USCM_CMD_RTS_ON])
      rts_q <= 1'b0;
    dtr_n_o <= dtr_q;
    // line driver control: high while transmitting in rs485
    rts_n_o <= (op_mode_o == `USCM_OPM_RS485) ? ~tx_idle_i : rts_q;
  end
end

// ---------------------------------------------------------------
// sticky status flags, set wins over clear
// ---------------------------------------------------------------
always @*
begin
  status_d = status_q;
  if (cmd[`USCM_CMD_STA_CLR])
  begin
    status_d[`USCM_ST_PAR] = 1'b0;
    status_d[`USCM_ST_FRAME] = 1'b0;
    status_d[`USCM_ST_OVR] = 1'b0;
    status_d[`USCM_ST_MANCH] = 1'b0;
    status_d[`USCM_ST_BREAK_SEEN_FLAG] = 1'b0;
  end
  if (cmd[`USCM_CMD_TO_ARM])
    status_d[`USCM_ST_TIMEOUT] = 1'b0;
  if (cmd[`USCM_CMD_ITER_CLR] && smartcard_mode)
    status_d[`USCM_ST_ITER] = 1'b0;
  status_d[`USCM_ST_PAR] = status_d[`USCM_ST_PAR] | parity_error_flag_i;
  status_d[`USCM_ST_FRAME] = status_d[`USCM_ST_FRAME] | frame_error_i;
  status_d[`USCM_ST_OVR] = status_d[`USCM_ST_OVR] | overrun_flag_i;
  status_d[`USCM_ST_MANCH] = status_d[`USCM_ST_MANCH] | manchester_error_flag_i;
  status_d[`USCM_ST_BREAK_SEEN_FLAG] = status_d[`USCM_ST_BREAK_SEEN_FLAG] | break_seen_flag_i;
  status_d[`USCM_ST_TIMEOUT] = status_d[`USCM_ST_TIMEOUT] | timeout_i;
  status_d[`USCM_ST_ITER] = status_d[`USCM_ST_ITER] | iteration_i;
end

always @(posedge clk_sys_i)
begin
  if (!rstn_i)
    status_q <= `USCM_RST_ZERO;
  else
    status_q <= status_d;
end

// ---------------------------------------------------------------
// break sequencer
// ---------------------------------------------------------------
assign brk_min = char_bits_o + `USCM_FRAME_EXTRA;

always @*
begin
  brk_state_d = brk_state_q;
  brk_cnt_d = brk_cnt_q;
  brk_stop_d = brk_stop_q;
  case (brk_state_q)
    BRK_IDLE:
    begin
      brk_stop_d = 1'b0;
      if (cmd[`USCM_CMD_BRK_BEGIN])
        brk_state_d = BRK_WAIT;
    end
    BRK_WAIT:
    begin
      brk_cnt_d = 4'h0;
      if (tx_idle_i)
        brk_state_d = BRK_LOW;
    end
    BRK_LOW:
    begin
      if (cmd[`USCM_CMD_BRK_END])
        brk_stop_d = 1'b1;
      if (bit_tick_i && brk_cnt_q < brk_min)
        brk_cnt_d = brk_cnt_q + 4'h1;
      if ((brk_stop_q || cmd[`USCM_CMD_BRK_END]) && brk_cnt_q >= brk_min)
      begin
        brk_state_d = BRK_GUARD;
        brk_cnt_d = 4'h0;
      end
    end
    BRK_GUARD:
    begin
      brk_stop_d = 1'b0;
      if (bit_tick_i)
        brk_cnt_d = brk_cnt_q + 4'h1;
      if (bit_tick_i && brk_cnt_q == `USCM_GUARD_BITS - 4'h1)
        brk_state_d = BRK_IDLE;
    end
    default:
      brk_state_d = BRK_IDLE;
  endcase
  if (cmd[`USCM_CMD_TX_RST])
  begin
    brk_state_d = BRK_IDLE;
    brk_stop_d = 1'b0;
  end
end

always @(posedge clk_sys_i)
begin
  if (!rstn_i)
  begin
    brk_state_q <= BRK_IDLE;
    brk_cnt_q <= 4'h0;
    brk_stop_q <= 1'b0;
    break_low_o <= 1'b0;
    break_guard_o <= 1'b0;
  end
  else
  begin
    brk_state_q <= brk_state_d;
    brk_cnt_q <= brk_cnt_d;
    brk_stop_q <= brk_stop_d;
    break_low_o <= brk_state_d == BRK_LOW;
    break_guard_o <= brk_state_d == BRK_GUARD;
  end
end

// ---------------------------------------------------------------
// axi4-lite read path
// ---------------------------------------------------------------
assign s_axi_arready_o = ~s_axi_rvalid_o;

always @*
begin
  rd_data = 32'h0;
  rd_resp = `USCM_RESP_OK;
  case ({s_axi_araddr_i[ADDR_W-1:2], 2'b00})
    `USCM_OFF_CMD, `USCM_OFF_IEN_SET, `USCM_OFF_IEN_CLR, `USCM_OFF_TX_HOLD:
      rd_data = 32'h0;
    `USCM_OFF_MODE: rd_data = mode_q;
    `USCM_OFF_IEN_VIEW: rd_data = ien_q;
    `USCM_OFF_STATUS: rd_data = status_q;
    `USCM_OFF_RX_HOLD: rd_data = {23'h0, rx_data_i};
    `USCM_OFF_BAUD: rd_data = baud_q;
    `USCM_OFF_RTO: rd_data = rto_q;
    `USCM_OFF_GUARD: rd_data = guard_q;
    `USCM_OFF_FIDI: rd_data = fidi_q;
    `USCM_OFF_NERR: rd_data = {24'h0, error_count_i};
    `USCM_OFF_IRF: rd_data = irf_q;
    `USCM_OFF_MAN: rd_data = man_q;
    `USCM_OFF_CTLVIEW:
      rd_data = {20'h0, brk_state_q, addr_pend_q, cfg_valid_o, timeout_wait_o,
        rts_q, dtr_q, tx_enable_o, rx_enable_o, 1'b0};
    default: rd_resp = `USCM_RESP_ERR;
  endcase
end

always @(posedge clk_sys_i)
begin
  if (!rstn_i)
  begin
    s_axi_rvalid_o <= 1'b0;
    s_axi_rdata_o <= 32'h0;
    s_axi_rresp_o <= `USCM_RESP_OK;
  end
  else if (s_axi_arvalid_i && !s_axi_rvalid_o)
  begin
    s_axi_rvalid_o <= 1'b1;
    s_axi_rdata_o <= rd_data;
    s_axi_rresp_o <= rd_resp;
  end
  else if (s_axi_rready_i)
    s_axi_rvalid_o <= 1'b0;
end

endmodule

// ==== testbench/uscm_props.sv ====
// assertion checker for the command and mode front end
`timescale 1ns/1ps
module uscm_props (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire rx_reset_o,
  input wire tx_reset_o,
  input wire rx_enable_o,
  input wire tx_enable_o,
  input wire dtr_n_o,
  input wire rts_n_o,
  input wire [3:0] op_mode_o,
  input wire [3:0] char_bits_o,
  input wire tx_idle_i,
  input wire bit_tick_i,
  input wire break_low_o,
  input wire break_guard_o
);
  reg [7:0] wa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg bv_q;
  reg [5:0] lcnt_q;
  reg [5:0] gcnt_q;
  wire wr_done = s_axi_bvalid_o && !bv_q;
  wire cmd_wr = wr_done && wa_q == 8'h00;
  wire [31:0] wm = wd_q & {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  // -----------------------------------------------------------
  // capture of the write in flight and tick counters
  // -----------------------------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      bv_q <= 1'b0;
      lcnt_q <= 6'h00;
      gcnt_q <= 6'h00;
    end
    else
    begin
      bv_q <= s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o)
        wa_q <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o)
        {wd_q, ws_q} <= {s_axi_wdata_i, s_axi_wstrb_i};
      lcnt_q <= !break_low_o ? 6'h00 : lcnt_q + {5'h00, bit_tick_i};
      gcnt_q <= !break_guard_o ? 6'h00 : gcnt_q + {5'h00, bit_tick_i};
    end
  end
  // -----------------------------------------------------------
  // properties
  // -----------------------------------------------------------
  chk_rx_reset_pulse: assert property (cmd_wr && wm[2] |-> ##[0:1] rx_reset_o)
    else $error("rx reset missing");
  chk_rx_reset_quiet: assert property (cmd_wr && !wm[2] |-> !rx_reset_o [*2])
    else $error("rx reset stray");
  chk_tx_reset_pulse: assert property (cmd_wr && wm[3] |-> ##[0:1] tx_reset_o)
    else $error("tx reset missing");
  chk_rx_enable_gate: assert property (cmd_wr && (wm[4] || wm[5]) |-> ##2
    rx_enable_o == (wm[4] && !wm[5])) else $error("rx enable wrong");
  chk_tx_enable_gate: assert property (cmd_wr && (wm[6] || wm[7]) |-> ##2
    tx_enable_o == (wm[6] && !wm[7])) else $error("tx enable wrong");
  chk_dtr_pin_level: assert property (cmd_wr && (wm[16] || wm[17]) |-> ##2
    dtr_n_o == wm[17]) else $error("dtr pin wrong");
  chk_rts_pin_level: assert property (cmd_wr && (wm[18] || wm[19]) && op_mode_o != 4'h1
    |-> ##2 rts_n_o == wm[19]) else $error("rts pin wrong");
  chk_char_len_sel: assert property (wr_done && wa_q == 8'h04 && ws_q == 4'hf |->
    char_bits_o == (wd_q[17] ? 4'h9 : 4'h5 + {2'h0, wd_q[7:6]}))
    else $error("char length wrong");
  chk_break_after_idle: assert property ($rose(break_low_o) |-> $past(tx_idle_i))
    else $error("break while busy");
  chk_break_min_len: assert property ($fell(break_low_o) |->
    lcnt_q >= {2'h0, char_bits_o} + 6'h02) else $error("break too short");
  chk_guard_bits: assert property ($fell(break_guard_o) |-> gcnt_q == 6'h0c)
    else $error("guard not twelve");
endmodule

// ==== testbench/uscm_peer.sv ====
// serial datapath stand-in: bit ticks, idle flag and receive events
`timescale 1ns/1ps
module uscm_peer (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire busy_i,
  input wire [7:0] fire_i,
  output reg tx_idle_o,
  output reg bit_tick_o,
  output reg [7:0] event_o
);
  reg [1:0] div_q;
  // one bit period every four clocks; events last one cycle
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      div_q <= 2'h0;
      bit_tick_o <= 1'b0;
      tx_idle_o <= 1'b1;
      event_o <= 8'h00;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      bit_tick_o <= div_q == 2'h3;
      tx_idle_o <= !busy_i;
      event_o <= fire_i;
    end
  end
endmodule

// ==== testbench/usart_control_mode_regs_tb_top.sv ====
// self-checking testbench for the command and mode front end
`timescale 1ns/1ps
module usart_control_mode_regs_tb_top;
  reg clk_sys_i, rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  reg s_axi_arvalid_i, s_axi_rready_i, busy, tv;
  reg [7:0] s_axi_awaddr_i, s_axi_araddr_i, fire;
  reg [31:0] s_axi_wdata_i;
  reg [3:0] s_axi_wstrb_i;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o, clk_src, stop_f, chan_f;
  wire [31:0] s_axi_rdata_o;
  wire tx_idle, bit_tick, rx_en, tx_en, t_wait, t_valid, t_addr, brk_low, brk_guard;
  wire dtr_n, rts_n, sync_m, msb_first_select, cfg_ok;
  wire [7:0] ev;
  wire [8:0] t_data;
  wire [3:0] op_m, chr;
  wire [2:0] par_f;
  int fail_count, compares, i, n;
  reg [1:0] r;
  reg [31:0] m;
  logic [36:0] rows [0:13] = '{{32'h0, 4'h5, 1'b1}, {32'h14241, 4'h6, 1'b1},
    {32'h8492, 4'h7, 1'b1}, {32'hc6f3, 4'h8, 1'b1}, {32'h20804, 4'h9, 1'b1},
    {32'h0b06, 4'h5, 1'b1}, {32'h0c08, 4'h5, 1'b1}, {32'h0e05, 4'h5, 1'b0},
    {32'h0020, 4'h5, 1'b0}, {32'h1000, 4'h5, 1'b1}, {32'h1100, 4'h5, 1'b0},
    {32'h2000, 4'h5, 1'b1}, {32'h3000, 4'h5, 1'b0}, {32'h0007, 4'h5, 1'b0}};
  // command, then {rx_en, tx_en, dtr_n, rts_n}
  logic [35:0] cmds [0:13] = '{{32'h50, 4'hf}, {32'h30, 4'h7}, {32'hc0, 4'h3},
    {32'h50, 4'hf}, {32'ha0, 4'h3}, {32'h10000, 4'h1}, {32'h30000, 4'h3},
    {32'h10000, 4'h1}, {32'h20000, 4'h3}, {32'h40000, 4'h2}, {32'hc0000, 4'h3},
    {32'h40000, 4'h2}, {32'h80000, 4'h3}, {32'h0c, 4'h3}};
  uscm_peer peer (.clk_sys_i, .rstn_i, .busy_i(busy), .fire_i(fire),
    .tx_idle_o(tx_idle), .bit_tick_o(bit_tick), .event_o(ev));
  uscm_core dut (.clk_sys_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awprot_i(3'h0), .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arprot_i(3'h0),
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .tx_idle_i(tx_idle), .bit_tick_i(bit_tick),
    .rx_char_i(ev[7]), .parity_error_flag_i(ev[0]), .frame_error_i(ev[1]),
    .overrun_flag_i(ev[2]), .manchester_error_flag_i(ev[3]), .break_seen_flag_i(ev[4]),
    .timeout_i(ev[5]), .iteration_i(ev[6]), .rx_data_i(9'h000), .error_count_i(8'h00),
    .rx_enable_o(rx_en), .tx_enable_o(tx_en), .rx_reset_o(), .tx_reset_o(),
    .timeout_wait_o(t_wait), .tx_data_o(t_data), .tx_data_valid_o(t_valid),
    .tx_addr_bit_o(t_addr), .break_low_o(brk_low), .break_guard_o(brk_guard),
    .dtr_n_o(dtr_n), .rts_n_o(rts_n), .op_mode_o(op_m), .clock_source_field_o(clk_src),
    .char_bits_o(chr), .sync_mode_o(sync_m), .parity_field_o(par_f),
    .stop_bits_field_o(stop_f), .channel_mode_field_o(chan_f), .msb_first_select_o(msb_first_select),
    .cfg_valid_o(cfg_ok), .baud_divider_o(), .rx_timeout_value_o(), .tx_guard_time_o(),
    .smartcard_rate_ratio_o(), .infrared_filter_o(), .manchester_config_o(),
    .irq_enable_o());
  // -----------------------------------------------------------
  // verdict, comparison and bus tasks
  // -----------------------------------------------------------
  task results;
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(input [63:0] seen, input [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task stall;
    fail_count++;
    results();
  endtask
  task wr(input [7:0] a, input [31:0] d);
    n = 0;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    r = 2'h3;
    while (r === 2'h3)
    begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_awready_o === 1'b1)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1)
        s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o === 1'b1)
        {tv, r} = {t_valid, s_axi_bresp_o};
      if (n > 40)
        stall();
    end
    s_axi_bready_i <= 1'b0;
    #1;
  endtask
  task rchk(input [7:0] a, input [1:0] er, input [31:0] e);
    n = 0;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_arready_o === 1'b1)
        s_axi_arvalid_i <= 1'b0;
      if (n > 40)
        stall();
    end
    while (s_axi_rvalid_o !== 1'b1);
    check({s_axi_rresp_o, s_axi_rdata_o}, {er, e});
    s_axi_rready_i <= 1'b0;
  endtask
  task cmd(input [31:0] d);
    wr(8'h00, d);
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  task pulse(input [7:0] f);
    @(posedge clk_sys_i);
    fire <= f;
    @(posedge clk_sys_i);
    fire <= 8'h00;
    repeat (3) @(posedge clk_sys_i);
  endtask
  task await(input int s, input bit v);
    n = 0;
    while ((s == 0 ? brk_low : brk_guard) !== v)
    begin
      @(posedge clk_sys_i);
      n++;
      if (n > 200)
        stall();
    end
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial
  begin
    {rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, busy} = 5'h00;
    {s_axi_arvalid_i, s_axi_rready_i, fire, s_axi_awaddr_i, s_axi_araddr_i} = 26'h0;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'hf;
    fail_count = 0;
    compares = 0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    #1 check({rx_en, tx_en, dtr_n, rts_n}, 4'h3);
    rchk(8'h10, 2'h0, 32'h0);
    rchk(8'h40, 2'h0, 32'h174);
    rchk(8'h50, 2'h0, 32'h3001_1004);
    for (i = 0; i < 14; i++)
    begin
      m = rows[i][36:5];
      wr(8'h04, m);
      check({msb_first_select, chan_f, stop_f}, m[16:12]);
      check({par_f, sync_m, clk_src, op_m}, {m[11:8], m[5:0]});
      check({chr, cfg_ok}, rows[i][4:0]);
      rchk(8'h04, 2'h0, m);
    end
    wr(8'h04, 32'h0);
    for (i = 0; i < 14; i++)
    begin
      cmd(cmds[i][35:4]);
      check({rx_en, tx_en, dtr_n, rts_n}, cmds[i][3:0]);
    end
    wr(8'h48, 32'hffff_ffff);
    check(r, 2'h2);
    rchk(8'h30, 2'h2, 32'h0);
    rchk(8'h00, 2'h0, 32'h0);
    wr(8'h10, 32'hffff_ffff);
    rchk(8'h10, 2'h0, 32'h0);
    wr(8'h20, 32'h1234_5678);
    rchk(8'h20, 2'h0, 32'h1234_5678);
    pulse(8'h7f);
    rchk(8'h14, 2'h0, 32'h0100_05e4);
    cmd(32'h100);
    rchk(8'h14, 2'h0, 32'h0000_0500);
    cmd(32'h2000);
    rchk(8'h14, 2'h0, 32'h0000_0500);
    cmd(32'h800);
    check(t_wait, 1'b1);
    rchk(8'h14, 2'h0, 32'h0000_0400);
    pulse(8'h80);
    check(t_wait, 1'b0);
    for (i = 4; i < 8; i += 2)
    begin
      pulse(8'h40);
      wr(8'h04, i);
      cmd(32'h2000);
      rchk(8'h14, 2'h0, 32'h0);
    end
    wr(8'h04, 32'h0c00);
    cmd(32'h1000);
    wr(8'h1c, 32'h1a5);
    check({tv, t_addr, t_data}, {2'h3, 9'h1a5});
    wr(8'h1c, 32'h055);
    check({t_addr, t_data}, {1'b0, 9'h055});
    wr(8'h04, 32'h0);
    cmd(32'h1000);
    wr(8'h1c, 32'h0aa);
    check({t_addr, t_data}, {1'b0, 9'h0aa});
    busy <= 1'b1;
    cmd(32'h200);
    repeat (8) @(posedge clk_sys_i);
    check(brk_low, 1'b0);
    busy <= 1'b0;
    await(0, 1'b1);
    cmd(32'h200);
    cmd(32'h400);
    await(1, 1'b1);
    check(brk_low, 1'b0);
    await(1, 1'b0);
    cmd(32'h50050);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    #1 check({rx_en, tx_en, dtr_n, rts_n, brk_low}, 5'h06);
    rchk(8'h04, 2'h0, 32'h0);
    results();
  end
endmodule
bind uscm_core uscm_props u_props (.clk_sys_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .rx_reset_o, .tx_reset_o, .rx_enable_o, .tx_enable_o, .dtr_n_o, .rts_n_o,
  .op_mode_o, .char_bits_o, .tx_idle_i, .bit_tick_i, .break_low_o, .break_guard_o);
